/* src/crc_pkg.sv */
//------------------------------------------------------------
// Shared constants and types for the card reader control
//------------------------------------------------------------
package crc_pkg;

  localparam int unsigned BUF_W       = 36;
  localparam int unsigned CHAR_W      = 6;
  localparam int unsigned CHAN_W      = 3;
  localparam logic [35:0] BUF_RESET   = 36'h0_0000_0000;
  localparam logic [2:0]  CHAN_NONE   = 3'h0;
  localparam logic [2:0]  UNIT_SIX    = 3'h6;

  // Characters per bus transfer, selected by program
  typedef enum logic [1:0] {
    CRC_UNIT_ONE = 2'b00,
    CRC_UNIT_TWO = 2'b01,
    CRC_UNIT_SIX = 2'b10
  } crc_unit_t;

  // Program command strobes
  typedef struct packed {
    logic start_cycle;
    logic retrieve;
  } crc_cmd_t;

  // Reader side strobes and levels
  typedef struct packed {
    logic       col_strobe;
    logic [5:0] col_low;
    logic [5:0] col_high;
    logic       card_start;
    logic       card_end;
    logic       card_jam;
    logic       eof_button;
    logic       hopper_empty;
    logic       validity_err;
    logic       read_err;
    logic       not_ready;
    logic       power_off;
  } crc_rdr_t;

  // Status levels toward the program
  typedef struct packed {
    logic busy;
    logic flag;
    logic card_cycle_complete;
    logic end_of_deck;
    logic read_fault_level;
    logic not_ready;
  } crc_stat_t;

  // Characters needed to fill one transfer unit
  function automatic logic [2:0] crc_unit_chars(input crc_unit_t u);
    unique case (u)
      CRC_UNIT_ONE: crc_unit_chars = 3'h1;
      CRC_UNIT_TWO: crc_unit_chars = 3'h2;
      default:      crc_unit_chars = UNIT_SIX;
    endcase
  endfunction : crc_unit_chars

endpackage : crc_pkg

/* src/crc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
//------------------------------------------------------------
module crc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Pin and clean level
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Take a bit once the last two stages agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= '0;
    end else begin
      o_level <= (s2 & s3) | (o_level & (s2 | s3));
    end
  end

endmodule : crc_sync
`default_nettype wire

/* src/crc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - 36-bit buffer, characters enter leftmost, line1 bit35
// R2 - Buffer bit n drives bus line n
// R3 - Program picks one, two or six characters
// R4 - Multi-character units shift older characters right
// R5 - Split mode: lower half first, upper second
// R6 - Normal mode: one converted character per column
// R7 - Busy from cycle request until card read
// R8 - Flag when selected amount is buffered
// R9 - Retrieve clears flag and buffer
// R10 - Unretrieved data dropped at next column
// R11 - Flag also on card end or jam
// R12 - Card complete held until next cycle starts
// R13 - Busy and card complete may coexist
// R14 - End of file with empty hopper sets flags
// R15 - Read fault on validity or read error
// R16 - Flag requests interrupt on assigned channel
// R17 - Not ready on any condition or power off
// R18 - Reset clears the buffer and all status except not ready, which reset sets
module crc_top
  import crc_pkg::*;
(
  // Clock and reset
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST,
  // Program side
  input  wire crc_cmd_t          I_CMD,
  input  wire crc_unit_t         I_UNIT,
  input  wire logic              I_COLUMN_SPLIT_MODE,
  input  wire logic [CHAN_W-1:0] I_INTERRUPT_CHANNEL_ASSIGN,
  output logic [BUF_W-1:0]       O_CARD_BUFFER,
  output var crc_stat_t          O_STAT,
  output logic [CHAN_W-1:0]      O_PRIORITY_INTERRUPT_CHAN,
  output logic                   O_PRIORITY_INTERRUPT,
  // Reader side pins
  input  wire crc_rdr_t          I_RDR
);

  localparam int unsigned RW = $bits(crc_rdr_t);

  crc_rdr_t   rdr;
  crc_rdr_t   rdr_d;
  logic [RW-1:0] rdr_bits;
  logic       col_ev;
  logic       start_ev;
  logic       end_ev;
  logic       jam_ev;
  logic       eof_ev;
  logic [BUF_W-1:0] card_buffer;
  logic [2:0] char_cnt;
  logic [2:0] next_cnt;
  logic       pending;
  logic       busy;
  logic       flag;
  logic       card_cycle_complete;
  logic       end_of_deck;
  logic       read_fault_level;
  logic       full_ev;
  logic       not_ready;

  //------------------------------------------------------------
  // Pin synchronisation and edge detection
  //------------------------------------------------------------
  crc_sync #(.W(RW)) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_pin   (I_RDR),
    .o_level (rdr_bits)
  );
  assign rdr = crc_rdr_t'(rdr_bits);

  // Previous clean levels for edge detect
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdr_d <= '0;
    end else begin
      rdr_d <= rdr;
    end
  end

  assign col_ev   = rdr.col_strobe & ~rdr_d.col_strobe;
  assign start_ev = rdr.card_start & ~rdr_d.card_start;
  assign end_ev   = rdr.card_end & ~rdr_d.card_end;
  assign jam_ev   = rdr.card_jam & ~rdr_d.card_jam;
  assign eof_ev   = rdr.eof_button & ~rdr_d.eof_button
                    & rdr.hopper_empty;

  //------------------------------------------------------------
  // Assembly buffer
  //------------------------------------------------------------
  // Reader line 1 goes to the highest index of its field
  function automatic logic [CHAR_W-1:0] line_order(
    input logic [CHAR_W-1:0] c
  );
    line_order = {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction : line_order

  // Count after this column; a dropped word restarts from zero
  always_comb begin
    next_cnt = (pending ? 3'h0 : char_cnt)
             + (I_COLUMN_SPLIT_MODE ? 3'h2 : 3'h1);
  end

  // Buffer full reached on this column
  assign full_ev = col_ev
    & (next_cnt >= crc_unit_chars(I_UNIT));

  // Shift characters in at the left
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      card_buffer <= BUF_RESET; // see R18
      char_cnt    <= 3'h0;
      pending     <= 1'b0;
    end else if (col_ev) begin
      if (pending) begin
        // Stale word dropped before the new column lands
        if (I_COLUMN_SPLIT_MODE) begin // see R10
          card_buffer <= {line_order(rdr.col_high),
                          line_order(rdr.col_low), 24'h00_0000};
        end else begin
          card_buffer <= {line_order(rdr.col_low), 30'h0000_0000};
        end
        char_cnt <= next_cnt;
        pending  <= full_ev;
      end else if (I_COLUMN_SPLIT_MODE) begin
        // Lower half then upper half, older data toward bit 0
        card_buffer <= {line_order(rdr.col_high), line_order(rdr.col_low),
                        card_buffer[35:12]}; // see R1, R2, R4, R5
        char_cnt <= next_cnt;
        pending  <= full_ev; // see R3
      end else begin
        card_buffer <= {line_order(rdr.col_low),
                        card_buffer[35:6]}; // see R6
        char_cnt <= next_cnt;
        pending  <= full_ev; // see R3
      end
    end else if (I_CMD.retrieve) begin
      card_buffer <= BUF_RESET; // see R9
      char_cnt    <= 3'h0;
      pending     <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Status bits
  //------------------------------------------------------------
  // Busy from request until card end or jam
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      busy <= 1'b0;
    end else if (I_CMD.start_cycle) begin
      busy <= 1'b1; // see R7, R13
    end else if (end_ev | jam_ev) begin
      busy <= 1'b0;
    end
  end

  // Flag: set wins over retrieve
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag <= 1'b0;
    end else if (full_ev | end_ev | jam_ev | eof_ev) begin
      flag <= 1'b1; // see R8, R11, R14
    end else if (I_CMD.retrieve | col_ev) begin
      flag <= 1'b0; // see R9
    end
  end

  // Card complete until the mechanical start
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      card_cycle_complete <= 1'b0;
    end else if (end_ev) begin
      card_cycle_complete <= 1'b1; // see R12
    end else if (start_ev) begin
      card_cycle_complete <= 1'b0; // see R13
    end
  end

  // End of deck, cleared by a new cycle request
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      end_of_deck <= 1'b0;
    end else if (eof_ev) begin
      end_of_deck <= 1'b1; // see R14
    end else if (I_CMD.start_cycle) begin
      end_of_deck <= 1'b0;
    end
  end

  // Read fault follows reader error lines
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      read_fault_level <= 1'b0;
    end else begin
      read_fault_level <= rdr.validity_err | rdr.read_err; // see R15
    end
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      not_ready <= 1'b1;
    end else begin
      not_ready <= rdr.not_ready | rdr.power_off; // see R17
    end
  end

  assign O_STAT.not_ready           = not_ready;

  assign O_CARD_BUFFER              = card_buffer; // see R2
  assign O_STAT.busy                = busy;
  assign O_STAT.flag                = flag;
  assign O_STAT.card_cycle_complete = card_cycle_complete;
  assign O_STAT.end_of_deck         = end_of_deck;
  assign O_STAT.read_fault_level    = read_fault_level;
  assign O_PRIORITY_INTERRUPT_CHAN  = I_INTERRUPT_CHANNEL_ASSIGN;
  assign O_PRIORITY_INTERRUPT       = flag
    & (I_INTERRUPT_CHANNEL_ASSIGN != CHAN_NONE); // see R16

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  a_busy_set: assert property (I_CMD.start_cycle |=> busy) // see R7
    else $error("busy not set by request");
  a_flag_full: assert property (full_ev |=> flag) // see R8
    else $error("flag not set when unit full");
  a_retr_clear: assert property (I_CMD.retrieve & ~col_ev |=>
    card_buffer == BUF_RESET) // see R9
    else $error("buffer not cleared on retrieve");
  a_flag_end: assert property (end_ev | jam_ev |=> flag) // see R11
    else $error("flag not set at card end or jam");
  a_done_hold: assert property (card_cycle_complete & ~start_ev
    |=> card_cycle_complete) // see R12
    else $error("card complete dropped early");
  a_eof_flag: assert property (eof_ev |=> end_of_deck & flag) // see R14
    else $error("end of deck not flagged");
  a_fault_lvl: assert property (rdr.read_err |=>
    read_fault_level) // see R15
    else $error("read fault missed");
  a_irq_chan: assert property (O_PRIORITY_INTERRUPT ==
    (flag & (I_INTERRUPT_CHANNEL_ASSIGN != 3'h0))) // see R16
    else $error("interrupt request mismatch");
  a_nr_power: assert property (rdr.power_off |=>
    O_STAT.not_ready) // see R17
    else $error("not ready missing at power off");
  a_shift_one: assert property (col_ev & ~pending
    & ~I_COLUMN_SPLIT_MODE |=> card_buffer[29:0]
    == $past(card_buffer[35:6])) // see R4
    else $error("older characters not shifted");

  c_full: cover property (full_ev ##1 flag);
  c_both: cover property (busy & card_cycle_complete);
  c_eof: cover property (eof_ev);
  c_drop: cover property (pending & col_ev);

endmodule : crc_top
`default_nettype wire

/* sim/crc_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// Behavioural card reader on the pin bundle
//------------------------------------------------------------
module crc_reader_model
  import crc_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Reader pins
  output var crc_rdr_t o_rdr
);
  crc_rdr_t rdr = '0;

  assign o_rdr = rdr;

  // One column: data settles, strobe pulses, then lines driven to their complement
  task automatic col(input logic [5:0] lo, input logic [5:0] hi);
    @(negedge i_clk);
    rdr.col_low = lo;
    rdr.col_high = hi;
    @(negedge i_clk);
    rdr.col_strobe = 1'b1;
    repeat (4) @(negedge i_clk);
    rdr.col_strobe = 1'b0;
    repeat (2) @(negedge i_clk);
    rdr.col_low = ~lo;
    rdr.col_high = ~hi;
    repeat (3) @(negedge i_clk);
  endtask : col

  // Single pin level, held long enough to pass the filter
  task automatic pin(input int k, input logic v);
    @(negedge i_clk);
    rdr[k] = v;
    repeat (6) @(negedge i_clk);
  endtask : pin
endmodule : crc_reader_model
`default_nettype wire

/* sim/tb_crc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_crc_top
  import crc_pkg::*;
;
  // Bit positions of single pins in the reader bundle
  localparam int START = 8, ENDC = 7, JAM = 6, EOFB = 5, HOPE = 4;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  crc_cmd_t          cmd = '0;
  crc_unit_t         unit = CRC_UNIT_SIX;
  logic              split = 1'b0;
  logic [CHAN_W-1:0] chan = 3'h0;
  logic [BUF_W-1:0]  buf_q;
  crc_stat_t         stat;
  logic [CHAN_W-1:0] pchan;
  logic              pint;
  crc_rdr_t          rdr;
  logic [35:0]       exp;
  int                mismatches = 0;
  int                n_tests = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  crc_top i_crc_top (
    .I_SYS_CLK(clk), .I_RST(rst), .I_CMD(cmd), .I_UNIT(unit),
    .I_COLUMN_SPLIT_MODE(split), .I_INTERRUPT_CHANNEL_ASSIGN(chan),
    .O_CARD_BUFFER(buf_q), .O_STAT(stat),
    .O_PRIORITY_INTERRUPT_CHAN(pchan), .O_PRIORITY_INTERRUPT(pint),
    .I_RDR(rdr));

  crc_reader_model i_crc_reader_model (.i_clk(clk), .o_rdr(rdr));

  // Compare and count
  task automatic chk(input logic [35:0] got, input logic [35:0] want);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  // Reader line 1 arrives as bit 0, lands at the high index
  function automatic logic [5:0] rv(input logic [5:0] c);
    return {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction : rv

  // One-cycle program strobe
  task automatic prog(input logic s, input logic r);
    @(negedge clk);
    cmd.start_cycle = s;
    cmd.retrieve = r;
    @(negedge clk);
    cmd = '0;
    @(negedge clk);
  endtask : prog

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Watchdog, well beyond the few hundred cycles needed
  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk(buf_q, 36'h0);
    chk(stat, 6'h00);
    prog(1'b1, 1'b0);
    chk(stat.busy, 1'b1);
    // Six converted columns fill one word
    exp = '0;
    for (int i = 1; i <= 6; i++) begin
      chk(stat.flag, 1'b0);
      i_crc_reader_model.col(6'(i * 9), 6'h3F);
      exp = {rv(6'(i * 9)), exp[35:6]};
    end
    chk(stat.flag, 1'b1);
    chk(buf_q, exp);
    // Interrupt follows the assigned channel
    chan = 3'h5;
    @(negedge clk);
    chk(pint, 1'b1);
    chk(pchan, 3'h5);
    chan = 3'h0;
    @(negedge clk);
    chk(pint, 1'b0);
    prog(1'b0, 1'b1);
    chk(stat.flag, 1'b0);
    chk(buf_q, 36'h0);
    // Unit of one, second column drops unretrieved data
    unit = CRC_UNIT_ONE;
    i_crc_reader_model.col(6'h21, 6'h00);
    chk(buf_q, {rv(6'h21), 30'h0});
    i_crc_reader_model.col(6'h0E, 6'h00);
    chk(buf_q, {rv(6'h0E), 30'h0});
    chk(stat.flag, 1'b1);
    // Unit of two
    prog(1'b0, 1'b1);
    unit = CRC_UNIT_TWO;
    i_crc_reader_model.col(6'h05, 6'h00);
    chk(stat.flag, 1'b0);
    i_crc_reader_model.col(6'h32, 6'h00);
    chk(buf_q, {rv(6'h32), rv(6'h05), 24'h0});
    // Unretrieved pair dropped, the new column alone does not fill
    i_crc_reader_model.col(6'h09, 6'h00);
    chk(buf_q, {rv(6'h09), 30'h0});
    chk(stat.flag, 1'b0);
    // Split column, lower half first
    prog(1'b0, 1'b1);
    split = 1'b1;
    i_crc_reader_model.col(6'h2B, 6'h14);
    chk(stat.flag, 1'b1);
    chk(buf_q, {rv(6'h14), rv(6'h2B), 24'h0});
    split = 1'b0;
    // Card end, new request, mechanical start
    prog(1'b0, 1'b1);
    i_crc_reader_model.pin(ENDC, 1'b1);
    i_crc_reader_model.pin(ENDC, 1'b0);
    chk(stat.busy, 1'b0);
    chk(stat.card_cycle_complete, 1'b1);
    chk(stat.flag, 1'b1);
    prog(1'b1, 1'b0);
    chk({stat.busy, stat.card_cycle_complete}, 2'h3);
    i_crc_reader_model.pin(START, 1'b1);
    i_crc_reader_model.pin(START, 1'b0);
    chk(stat.card_cycle_complete, 1'b0);
    // Jam
    prog(1'b0, 1'b1);
    i_crc_reader_model.pin(JAM, 1'b1);
    i_crc_reader_model.pin(JAM, 1'b0);
    chk({stat.busy, stat.flag}, 2'h1);
    // End of file needs an empty hopper
    prog(1'b0, 1'b1);
    i_crc_reader_model.pin(EOFB, 1'b1);
    i_crc_reader_model.pin(EOFB, 1'b0);
    chk(stat.end_of_deck, 1'b0);
    i_crc_reader_model.pin(HOPE, 1'b1);
    i_crc_reader_model.pin(EOFB, 1'b1);
    i_crc_reader_model.pin(EOFB, 1'b0);
    chk({stat.end_of_deck, stat.flag}, 2'h3);
    i_crc_reader_model.pin(HOPE, 1'b0);
    // Error and not-ready levels: power off, not ready, read, validity
    for (int k = 0; k < 4; k++) begin
      i_crc_reader_model.pin(k, 1'b1);
      chk(k > 1 ? stat.read_fault_level : stat.not_ready, 1'b1);
      i_crc_reader_model.pin(k, 1'b0);
      chk(k > 1 ? stat.read_fault_level : stat.not_ready, 1'b0);
    end
    results();
  end
endmodule : tb_crc_top
`default_nettype wire
